// ===== stop_mode_ctrl.sv
// deep stop state controller: clock gating, wake-up and stabilisation
// assumes the register port and interrupt request share i_clk; the
// nmi, bus hold request and subclock strap arrive from pins
`timescale 1ns/100ps

module stop_mode_ctrl
    import stop_ctrl_pkg::*;
#(
    parameter int STAB_EXP_BASE = 13
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [stop_ctrl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [stop_ctrl_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [stop_ctrl_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_nmi,
    input wire logic i_irq_unmasked,
    input wire logic i_bus_hold_request,
    input wire logic i_subclock_present,
    output logic o_main_osc_en,
    output logic o_main_clk_en,
    output logic o_sub_osc_en,
    output logic o_sub_clk_en,
    output logic o_sub_feedback_cut,
    output logic o_cpu_run,
    output logic o_wake_to_handler,
    output logic o_bus_hold_acknowledge,
    output logic o_first_wide_timer_run,
    output logic o_second_wide_timer_run,
    output logic o_fifth_narrow_timer_run,
    output logic o_sixth_narrow_timer_run,
    output logic o_seventh_narrow_timer_run,
    output logic o_eighth_narrow_timer_run,
    output logic o_watch_timer_run,
    output logic [3:0] o_clocked_serial_channels_run,
    output logic o_fifth_clocked_serial_channel_run,
    output logic [1:0] o_uart_tx_run,
    output logic [1:0] o_uart_rx_run,
    output logic o_real_time_output_run,
    output logic o_seventh_external_irq_run,
    output logic o_first_four_external_irqs_run,
    output logic o_fifth_sixth_external_irqs_run,
    output logic o_nmi_input_run,
    output logic o_key_return_run,
    output logic o_watchdog_run,
    output logic o_dma_run,
    output logic o_adc_run,
    output logic o_two_wire_serial_run,
    output logic o_port_hold,
    output logic o_ext_bus_float
);
    import stop_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    localparam int MAX_EXP = STAB_EXP_BASE + STAB_EXP_STEP * 7;

    if (STAB_EXP_BASE < 1 || MAX_EXP > 31) begin : g_bad_exp
        $error("stabilisation exponent out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // pin order in the synchroniser vectors: 0 nmi, 1 hold, 2 subclock
    typedef struct packed {
        mode_e mode;
        logic [31:0] stab_cnt;
        logic woke_by_irq;
        logic wake_pulse;
        logic stop_req;
        logic prot_armed;
        logic [7:0] proc_clk_ctrl;
        logic [2:0] stab_sel;
        logic [7:0] timer_src;
        logic [7:0] serial_src;
        logic [7:0] rd_data;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] pin;
    } state_s;

    state_s q;
    state_s next_q;

    logic halted;
    logic sub_ok;
    logic nmi_lvl;
    logic hold_lvl;
    logic wide_runs;
    logic fifth_runs;
    logic sixth_runs;
    logic [31:0] stab_last;
    logic [4:0] stab_exp;

    assign nmi_lvl = q.pin[0];
    assign hold_lvl = q.pin[1];
    assign sub_ok = q.pin[2];
    assign halted = (q.mode != ST_RUN);

    // the wait length is a power of two, so the last count is 2^n - 1
    assign stab_exp = 5'(STAB_EXP_BASE) +
                      5'({q.stab_sel, 1'b0});
    assign stab_last = (32'h1 << stab_exp) - 32'h1;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.wake_pulse = 1'b0;

        // a pin counts as changed once the second and third stages agree
        next_q.sync1 = {i_subclock_present, i_bus_hold_request, i_nmi};
        next_q.sync2 = q.sync1;
        next_q.sync3 = q.sync2;
        next_q.pin = (q.sync2 & ~(q.sync2 ^ q.sync3)) |
                     (q.pin & (q.sync2 ^ q.sync3));

        next_q.rd_data = 8'h00;
        if (i_rd_en) begin
            unique case (i_addr)
                OFS_PROC_CLK_CTRL: next_q.rd_data = q.proc_clk_ctrl;
                OFS_POWER_SAVE: next_q.rd_data = {7'h00, q.stop_req};
                OFS_STAB_SEL: next_q.rd_data = {5'h00, q.stab_sel};
                OFS_TIMER_SRC: next_q.rd_data = q.timer_src;
                OFS_SERIAL_SRC: next_q.rd_data = q.serial_src;
                OFS_STATUS: next_q.rd_data = {4'h0, hold_lvl, sub_ok,
                        q.mode == ST_STAB, q.mode == ST_STOP};
                default: next_q.rd_data = 8'h00;
            endcase
        end

        if (i_wr_en) begin
            // any write other than the command write disarms the key
            next_q.prot_armed = (i_addr == OFS_PROT_CMD);
            unique case (i_addr)
                OFS_PROC_CLK_CTRL: next_q.proc_clk_ctrl = {5'h00,
                        i_wr_data[2:0]};
                OFS_STAB_SEL: next_q.stab_sel = i_wr_data[2:0];
                OFS_TIMER_SRC: next_q.timer_src = i_wr_data;
                OFS_SERIAL_SRC: next_q.serial_src = i_wr_data;
                default: ;
            endcase
            // a stop write is only honoured straight after the key, with
            // the cpu on the main clock; otherwise it is dropped silently
            if (i_addr == OFS_POWER_SAVE && q.mode == ST_RUN &&
                    i_wr_data[BIT_STOP_REQ] && q.prot_armed &&
                    !q.proc_clk_ctrl[BIT_CPU_ON_SUB]) begin
                next_q.stop_req = 1'b1;
                next_q.mode = ST_STOP;
            end
        end

        unique case (q.mode)
            ST_RUN: ;
            ST_STOP: begin
                if (nmi_lvl || i_irq_unmasked) begin
                    next_q.mode = ST_STAB;
                    next_q.stab_cnt = 32'h0;
                    next_q.woke_by_irq = 1'b1;
                end
            end
            ST_STAB: begin
                if (q.stab_cnt >= stab_last) begin
                    next_q.mode = ST_RUN;
                    next_q.stop_req = 1'b0;
                    next_q.woke_by_irq = 1'b0;
                    next_q.wake_pulse = q.woke_by_irq;
                end else begin
                    next_q.stab_cnt = q.stab_cnt + 32'h1;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset lands in the stabilisation wait with the default select,
    // so a reset release also waits out the oscillator start
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.mode <= ST_STAB;
            q.stab_cnt <= 32'h0;
            q.woke_by_irq <= 1'b0;
            q.wake_pulse <= 1'b0;
            q.stop_req <= 1'b0;
            q.prot_armed <= 1'b0;
            q.proc_clk_ctrl <= RST_PROC_CLK_CTRL;
            q.stab_sel <= RST_STAB_SEL;
            q.timer_src <= RST_SRC;
            q.serial_src <= RST_SRC;
            q.rd_data <= 8'h00;
            q.sync1 <= 3'h0;
            q.sync2 <= 3'h0;
            q.sync3 <= 3'h0;
            q.pin <= 3'h0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // clock and unit enables
    // ----------------------------------------------------------------
    assign o_rd_data = q.rd_data;
    assign o_main_osc_en = (q.mode != ST_STOP);
    // clocks stay withheld through the wait; registers and RAM hold
    assign o_main_clk_en = !halted;
    assign o_cpu_run = !halted;
    assign o_sub_osc_en = 1'b1;
    assign o_sub_clk_en = 1'b1;
    assign o_sub_feedback_cut = halted &&
        q.proc_clk_ctrl[BIT_FEEDBACK_CUT];
    assign o_wake_to_handler = q.wake_pulse;
    assign o_bus_hold_acknowledge = hold_lvl && !halted;

    assign wide_runs = !halted || (q.timer_src[BIT_WT_TO_WIDE] &&
        q.timer_src[BIT_WATCH_SUB] && sub_ok);
    assign fifth_runs = !halted ||
        (q.timer_src[BIT_FIFTH_SUB] && sub_ok);
    assign sixth_runs = !halted ||
        (q.timer_src[BIT_SIXTH_SUB] && sub_ok);

    assign o_first_wide_timer_run = wide_runs;
    assign o_second_wide_timer_run = !halted;
    assign o_fifth_narrow_timer_run = fifth_runs;
    assign o_sixth_narrow_timer_run = sixth_runs;
    assign o_seventh_narrow_timer_run = !halted ||
        (q.timer_src[BIT_SEVENTH_OUT] && wide_runs);
    assign o_eighth_narrow_timer_run = !halted ||
        (q.timer_src[BIT_EIGHTH_OUT] && wide_runs);
    assign o_watch_timer_run = !halted ||
        (q.timer_src[BIT_WATCH_SUB] && sub_ok);

    assign o_clocked_serial_channels_run = {4{!halted}} |
        q.serial_src[BIT_CLK_SER_LO +: 4];
    assign o_fifth_clocked_serial_channel_run = !halted ||
        q.serial_src[BIT_CLK_SER5];
    // receive needs the main clock for sampling, so it always stops
    assign o_uart_tx_run = {2{!halted}} |
        q.serial_src[BIT_UART_LO +: 2];
    assign o_uart_rx_run = {2{!halted}};

    assign o_real_time_output_run = !halted ||
        (q.timer_src[BIT_RTO_FIFTH] && fifth_runs && sub_ok) ||
        (q.timer_src[BIT_RTO_SIXTH] && sixth_runs && sub_ok);
    assign o_seventh_external_irq_run = !halted ||
        (q.serial_src[BIT_IRQ7_SUB] && sub_ok);

    assign o_first_four_external_irqs_run = 1'b1;
    assign o_nmi_input_run = 1'b1;
    assign o_key_return_run = 1'b1;
    assign o_fifth_sixth_external_irqs_run = !halted;
    assign o_watchdog_run = !halted;
    assign o_dma_run = !halted;
    assign o_adc_run = !halted;
    assign o_two_wire_serial_run = !halted;
    assign o_port_hold = halted;
    assign o_ext_bus_float = halted &&
        q.proc_clk_ctrl[BIT_EXPANSION];

endmodule

// ===== stop_ctrl_pkg.sv
// constants for the deep stop state controller
// assumes one 125 MHz clock and an 8-bit register port

package stop_ctrl_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [3:0] OFS_PROC_CLK_CTRL = 4'h0;
    localparam logic [3:0] OFS_POWER_SAVE = 4'h1;
    localparam logic [3:0] OFS_STAB_SEL = 4'h2;
    localparam logic [3:0] OFS_PROT_CMD = 4'h3;
    localparam logic [3:0] OFS_TIMER_SRC = 4'h4;
    localparam logic [3:0] OFS_SERIAL_SRC = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_CPU_ON_SUB = 0;
    localparam int BIT_FEEDBACK_CUT = 1;
    localparam int BIT_EXPANSION = 2;
    localparam int BIT_STOP_REQ = 0;
    localparam int BIT_WT_TO_WIDE = 0;
    localparam int BIT_WATCH_SUB = 1;
    localparam int BIT_FIFTH_SUB = 2;
    localparam int BIT_SIXTH_SUB = 3;
    localparam int BIT_SEVENTH_OUT = 4;
    localparam int BIT_EIGHTH_OUT = 5;
    localparam int BIT_RTO_FIFTH = 6;
    localparam int BIT_RTO_SIXTH = 7;
    localparam int BIT_CLK_SER_LO = 0;
    localparam int BIT_CLK_SER5 = 4;
    localparam int BIT_UART_LO = 5;
    localparam int BIT_IRQ7_SUB = 7;
    localparam int STAB_SEL_W = 3;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PROC_CLK_CTRL = 8'h00;
    localparam logic [7:0] RST_SRC = 8'h00;
    localparam logic [2:0] RST_STAB_SEL = 3'h3;
    localparam int STAB_EXP_STEP = 2;

    typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_STAB} mode_e;

endpackage

// ===== stop_mode_ctrl_checker.sv
// checker for the stop controller: clock gating, wake-up, unit gating
// assumes it is bound into the controller and sees only its ports
`timescale 1ns/100ps
module stop_mode_ctrl_checker #(
    parameter int STAB_EXP_BASE = 13
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_irq_unmasked,
    input wire logic o_main_osc_en,
    input wire logic o_main_clk_en,
    input wire logic o_cpu_run,
    input wire logic o_wake_to_handler,
    input wire logic o_bus_hold_acknowledge,
    input wire logic o_sub_feedback_cut,
    input wire logic o_watchdog_run,
    input wire logic o_port_hold,
    input wire logic o_first_wide_timer_run,
    input wire logic o_fifth_narrow_timer_run,
    input wire logic o_sixth_narrow_timer_run,
    input wire logic o_seventh_narrow_timer_run,
    input wire logic o_real_time_output_run
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_stop_clk_off: assert property (!o_main_osc_en |-> !o_main_clk_en)
        else $error("main clock delivered while oscillator halted");
    a_wake_exit: assert property (!o_main_osc_en && i_irq_unmasked |=>
        o_main_osc_en && !o_cpu_run) else $error("no wake on interrupt");
    a_stab_wait: assert property ($rose(o_main_osc_en) |->
        !o_cpu_run ##1 !o_cpu_run) else $error("wait cut short");
    a_wake_pulse: assert property (o_wake_to_handler |->
        $rose(o_cpu_run) && o_main_clk_en) else $error("stray wake pulse");
    a_hold_refuse: assert property (o_bus_hold_acknowledge |-> o_cpu_run)
        else $error("hold acknowledged while halted");
    a_feedback_halt: assert property (o_sub_feedback_cut |-> !o_cpu_run)
        else $error("feedback cut while running");
    a_halt_units: assert property (!o_cpu_run |->
        !o_watchdog_run && o_port_hold) else $error("unit live while halted");
    a_narrow_chain: assert property (!o_cpu_run &&
        o_seventh_narrow_timer_run |-> o_first_wide_timer_run)
        else $error("seventh timer runs without wide timer");
    a_rto_chain: assert property (!o_cpu_run && o_real_time_output_run
        |-> o_fifth_narrow_timer_run || o_sixth_narrow_timer_run)
        else $error("real-time output without a running trigger timer");
    c_wake: cover property (o_wake_to_handler);
    c_hold: cover property (o_bus_hold_acknowledge);
    c_chain: cover property (!o_cpu_run && o_seventh_narrow_timer_run);
endmodule

bind stop_mode_ctrl stop_mode_ctrl_checker
    #(.STAB_EXP_BASE(STAB_EXP_BASE)) u_chk (.*);

// ===== stop_irq_source.sv
// interrupt source model facing the stop controller
// assumes fire strobes come from the bench on the controller clock
`timescale 1ns/100ps
module stop_irq_source (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_fire_irq,
    input wire logic i_fire_nmi,
    input wire logic i_wake_to_handler,
    output logic o_irq_unmasked,
    output logic o_nmi
);
    // level request held until the handler is entered, like a real source
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_unmasked <= 1'b0;
            o_nmi <= 1'b0;
        end else if (i_wake_to_handler) begin
            o_irq_unmasked <= 1'b0;
            o_nmi <= 1'b0;
        end else begin
            o_irq_unmasked <= o_irq_unmasked | i_fire_irq;
            o_nmi <= o_nmi | i_fire_nmi;
        end
    end
endmodule

// ===== test_stop_mode_ctrl.sv
// self-checking bench for the stop controller
// assumes the controller, its package, checker and irq source model
`timescale 1ns/100ps
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        bad_count++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module test_stop_mode_ctrl;
    import stop_ctrl_pkg::*;
    typedef struct {logic [7:0] ctl, ts, ss; logic sub;
        logic [7:0] ex;} row_s;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
    logic [3:0] i_addr = 4'h0, o_clocked_serial_channels_run;
    logic [7:0] i_wr_data = 8'h00, o_rd_data, unit_run, clk_state, halt_set;
    logic [7:0] exp_clk;
    logic [6:0] ser_run;
    logic [3:0] main_only;
    logic i_bus_hold_request = 1'b0, i_subclock_present = 1'b0;
    logic fire_irq = 1'b0, fire_nmi = 1'b0, w, i_nmi, i_irq_unmasked;
    logic o_main_osc_en, o_main_clk_en, o_sub_osc_en, o_sub_clk_en, o_cpu_run;
    logic o_sub_feedback_cut, o_wake_to_handler, o_bus_hold_acknowledge;
    logic o_first_wide_timer_run, o_second_wide_timer_run, o_watch_timer_run;
    logic o_fifth_narrow_timer_run, o_sixth_narrow_timer_run, o_dma_run;
    logic o_seventh_narrow_timer_run, o_eighth_narrow_timer_run, o_adc_run;
    logic o_fifth_clocked_serial_channel_run, o_real_time_output_run;
    logic [1:0] o_uart_tx_run, o_uart_rx_run;
    logic o_seventh_external_irq_run, o_first_four_external_irqs_run;
    logic o_fifth_sixth_external_irqs_run, o_nmi_input_run, o_key_return_run;
    logic o_watchdog_run, o_two_wire_serial_run, o_port_hold, o_ext_bus_float;
    int n, bad_count = 0, cmp_count = 0;
    row_s rows[6] = '{'{8'h06, 8'hFF, 8'hFF, 1'b1, 8'hFF},
        '{8'h00, 8'hFF, 8'hFF, 1'b0, 8'h00},
        '{8'h06, 8'h41, 8'h80, 1'b1, 8'h01},
        '{8'h00, 8'h36, 8'h00, 1'b1, 8'h44},
        '{8'h06, 8'hB3, 8'h15, 1'b1, 8'h9C},
        '{8'h00, 8'h8A, 8'h6A, 1'b1, 8'h26}};
    assign unit_run = {o_first_wide_timer_run, o_fifth_narrow_timer_run,
        o_sixth_narrow_timer_run, o_seventh_narrow_timer_run,
        o_eighth_narrow_timer_run, o_watch_timer_run, o_real_time_output_run,
        o_seventh_external_irq_run};
    assign clk_state = {o_main_osc_en, o_main_clk_en, o_cpu_run,
        o_bus_hold_acknowledge, o_sub_feedback_cut, o_ext_bus_float,
        o_sub_osc_en, o_sub_clk_en};
    assign halt_set = {o_watchdog_run, o_dma_run, o_adc_run,
        o_two_wire_serial_run, o_port_hold, o_nmi_input_run,
        o_first_four_external_irqs_run, o_key_return_run};
    assign ser_run = {o_uart_tx_run, o_fifth_clocked_serial_channel_run,
        o_clocked_serial_channels_run};
    // units that only ever run from the main clock
    assign main_only = {o_second_wide_timer_run, o_uart_rx_run,
        o_fifth_sixth_external_irqs_run};
    // short base keeps the default wait at 2^7 cycles
    stop_mode_ctrl #(.STAB_EXP_BASE(1)) uut (.*);
    stop_irq_source irq_src (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_fire_irq(fire_irq), .i_fire_nmi(fire_nmi),
        .i_wake_to_handler(o_wake_to_handler),
        .o_irq_unmasked(i_irq_unmasked), .o_nmi(i_nmi));
    always #4 i_clk = ~i_clk;
    // ----------------------------------------------------------------
    // bus and wait tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        i_rd_en <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic idle;
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd_en <= 1'b1;
        i_wr_en <= 1'b0;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 `CHK(o_rd_data, e)
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_run;
        n = 0;
        w = 1'b0;
        while (o_cpu_run !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            #1 n++;
            w = w | (o_wake_to_handler === 1'b1);
        end
        if (n >= 400) begin
            bad_count++;
            conclude;
        end
    endtask
    task automatic reset_chk;
        i_arst_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        wait_run;
        `CHK(n >= 127 && n <= 130, 1'b1)
        `CHK(w, 1'b0)
        rd(OFS_STAB_SEL, 8'h03);
    endtask
    task automatic enter_stop;
        wr(OFS_PROT_CMD, 8'h5A);
        wr(OFS_POWER_SAVE, 8'h01);
        idle;
        #1;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_chk;
        rd(OFS_TIMER_SRC, 8'h00);
        rd(OFS_PROC_CLK_CTRL, 8'h00);
        rd(4'hF, 8'h00);
        wr(OFS_STAB_SEL, 8'h00);
        i_bus_hold_request <= 1'b1;
        foreach (rows[k]) begin
            wr(OFS_PROC_CLK_CTRL, rows[k].ctl);
            wr(OFS_TIMER_SRC, rows[k].ts);
            wr(OFS_SERIAL_SRC, rows[k].ss);
            i_subclock_present <= rows[k].sub;
            repeat (6) idle;
            enter_stop;
            `CHK(unit_run, rows[k].ex)
            `CHK(ser_run, rows[k].ss[6:0])
            `CHK(main_only, 4'h0)
            exp_clk = {4'h0, rows[k].ctl[1], rows[k].ctl[2], 2'b11};
            `CHK(clk_state, exp_clk)
            `CHK(halt_set, 8'h0F)
            rd(OFS_STATUS, {5'h01, rows[k].sub, 2'b01});
            rd(OFS_POWER_SAVE, 8'h01);
            if (k % 2)
                fire_nmi <= 1'b1;
            else
                fire_irq <= 1'b1;
            @(posedge i_clk);
            fire_nmi <= 1'b0;
            fire_irq <= 1'b0;
            wait_run;
            `CHK(w, 1'b1)
            rd(OFS_TIMER_SRC, rows[k].ts);
            `CHK({o_bus_hold_acknowledge, o_port_hold}, 2'b10)
            `CHK(unit_run, 8'hFF)
            `CHK(main_only, 4'hF)
            `CHK(halt_set, 8'hF7)
            `CHK(clk_state, 8'hF3)
            rd(OFS_SERIAL_SRC, rows[k].ss);
            rd(OFS_POWER_SAVE, 8'h00);
        end
        // a key broken by another write, then a cpu on the subclock
        wr(OFS_PROT_CMD, 8'h00);
        wr(OFS_TIMER_SRC, 8'h00);
        wr(OFS_POWER_SAVE, 8'h01);
        idle;
        #1 `CHK(o_cpu_run, 1'b1)
        wr(OFS_PROC_CLK_CTRL, 8'h01);
        enter_stop;
        `CHK(o_cpu_run, 1'b1)
        wr(OFS_PROC_CLK_CTRL, 8'h00);
        enter_stop;
        `CHK(o_main_osc_en, 1'b0)
        reset_chk;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        conclude;
    end
endmodule
